// ==== rsc_params.svh ====
// Notes on behaviour
// - guard value other than 55h or AAh forces full reset after soft delay.
// - guard register powers up holding 55h.
// - guard corruption reset sets cause bit 3.
// - guard flag only set by hardware; software writing zero clears it.
// - all resets restore guard except watchdog timeout warm reset.
// - cause register bits 7 to 4 always read zero.
// - brownout reset only when low supply lasts beyond qualify time.
// - qualified brownout reset sets cause bit 2; only software zero clears.
// - brownout config decodes five level codes plus one disable code.
// - undefined brownout config resets after soft delay, restoring 66h.
// - genuine brownout reset leaves brownout config unchanged.
// - undefined brownout config reset sets cause bit 1; software clears.
// - brownout config powers up holding 66h (1.7 V level).
// - brownout detection and reset suppressed in IDLE or SLEEP.
// - writing 55h to first flash control register resets the device.
// - watchdog timeout in FAST or SLOW resets device, sets timeout flag.
// - corrupted watchdog control reset sets cause bit 0; software clears.
// - watchdog timeout in power save clears PC and SP, sets both flags.
`ifndef RSC_PARAMS_SVH
`define RSC_PARAMS_SVH
// register byte offsets
`define RSC_OFF_GUARD 12'h000
`define RSC_OFF_CAUSE 12'h004
`define RSC_OFF_BOCFG 12'h008
`define RSC_OFF_FLASH 12'h00C
`define RSC_OFF_STAT 12'h010
`define RSC_OFF_IRQS 12'h014
`define RSC_OFF_IRQM 12'h018
// values
`define RSC_GUARD_POR 8'h55
`define RSC_GUARD_ALT 8'hAA
`define RSC_BO_POR 8'h66
`define RSC_BO_1V9 8'h55
`define RSC_BO_2V55 8'h33
`define RSC_BO_3V15 8'h99
`define RSC_BO_3V8 8'hAA
`define RSC_BO_OFF 8'hF0
`define RSC_FLASH_KEY 8'h55
// cause bit positions
`define RSC_B_WDCFG 0
`define RSC_B_BOCFG 1
`define RSC_B_BO 2
`define RSC_B_GUARD 3
// timing
`define RSC_CLK_NS 10
`define RSC_SOFT_NS 1000
`define RSC_BO_NS 2000
`define RSC_SOFT_CYC ((`RSC_SOFT_NS + `RSC_CLK_NS - 1) / `RSC_CLK_NS)
`define RSC_BO_CYC ((`RSC_BO_NS + `RSC_CLK_NS - 1) / `RSC_CLK_NS)
`endif

// ==== rsc_pkg.sv ====
package rsc_pkg;
    // soft reset delay states
    typedef enum logic [0:0] {
        SD_IDLE = 1'b0,
        SD_WAIT = 1'b1
    } rsc_sd_t;
    // decoded brownout level index
    typedef logic [2:0] rsc_lvl_t;
endpackage : rsc_pkg

// ==== rsc_top.sv ====
// The register addresses and the APB interface to the registers are this design's own decisions.
`timescale 1ns/1ps
`include "rsc_params.svh"
module rsc_top
    import rsc_pkg::*;
#(
    parameter int SOFT_CYC = `RSC_SOFT_CYC,
    parameter int BO_CYC = `RSC_BO_CYC
)
(
    input wire logic I_CORE_CLK,
    input wire logic I_RST_B,
    input wire logic I_PSEL,
    input wire logic I_PENABLE,
    input wire logic I_PWRITE,
    input wire logic [11:0] I_PADDR,
    input wire logic [31:0] I_PWDATA,
    output logic [31:0] O_PRDATA,
    output logic O_PREADY,
    output logic O_PSLVERR,
    input wire logic I_LOW_SUPPLY,
    input wire logic I_POWER_SAVE,
    input wire logic I_WDT_TIMEOUT,
    input wire logic I_WDT_CFG_BAD,
    output logic O_SYS_RST,
    output logic O_PC_SP_CLR,
    output logic O_BROWNOUT_EN,
    output logic [2:0] O_BROWNOUT_LEVEL,
    output logic O_IRQ
);
    localparam logic [15:0] SOFT_LAST = 16'(SOFT_CYC - 1);
    localparam logic [15:0] BO_LAST = 16'(BO_CYC);

    // brownout code decode: {valid, disabled, level}
    function automatic logic [4:0] bo_decode(input logic [7:0] v);
        case (v)
            `RSC_BO_POR: bo_decode = {2'b10, 3'h0};
            `RSC_BO_1V9: bo_decode = {2'b10, 3'h1};
            `RSC_BO_2V55: bo_decode = {2'b10, 3'h2};
            `RSC_BO_3V15: bo_decode = {2'b10, 3'h3};
            `RSC_BO_3V8: bo_decode = {2'b10, 3'h4};
            `RSC_BO_OFF: bo_decode = {2'b11, 3'h0};
            default: bo_decode = {2'b00, 3'h0};
        endcase
    endfunction : bo_decode

    logic [7:0] reset_guard;
    logic [7:0] brownout_cfg;
    logic [3:0] reset_cause;
    logic [1:0] wdt_stat;
    logic [1:0] irq_stat;
    logic [1:0] irq_mask;
    logic [2:0] pend;
    rsc_sd_t sd_state;
    rsc_sd_t next_sd_state;
    logic [15:0] sd_cnt;
    logic [15:0] bo_cnt;

    // bus decode
    wire wr_en = I_PSEL & I_PENABLE & I_PWRITE;
    wire rd_setup = I_PSEL & ~I_PENABLE & ~I_PWRITE;
    wire hit_guard = I_PADDR == `RSC_OFF_GUARD;
    wire hit_cause = I_PADDR == `RSC_OFF_CAUSE;
    wire hit_bocfg = I_PADDR == `RSC_OFF_BOCFG;
    wire hit_flash = I_PADDR == `RSC_OFF_FLASH;
    wire hit_stat = I_PADDR == `RSC_OFF_STAT;
    wire hit_irqs = I_PADDR == `RSC_OFF_IRQS;
    wire hit_irqm = I_PADDR == `RSC_OFF_IRQM;
    wire hit = hit_guard | hit_cause | hit_bocfg | hit_flash | hit_stat
        | hit_irqs | hit_irqm;
    wire [7:0] wd = I_PWDATA[7:0];
    assign O_PREADY = 1'b1;
    assign O_PSLVERR = I_PSEL & I_PENABLE & ~hit;

    // corruption and event detection
    wire guard_ok = (reset_guard == `RSC_GUARD_POR)
        | (reset_guard == `RSC_GUARD_ALT);
    wire [4:0] bo_dec = bo_decode(brownout_cfg);
    wire cfg_ok = bo_dec[4];
    wire bo_en = cfg_ok & ~bo_dec[3] & ~I_POWER_SAVE;
    wire soft_fire = (sd_state == SD_WAIT) & (sd_cnt == SOFT_LAST);
    wire bo_fire = bo_en & I_LOW_SUPPLY & (bo_cnt == BO_LAST);
    wire flash_fire = wr_en & hit_flash & (wd == `RSC_FLASH_KEY);
    wire wdt_full = I_WDT_TIMEOUT & ~I_POWER_SAVE;
    wire wdt_warm = I_WDT_TIMEOUT & I_POWER_SAVE;
    wire full_rst = soft_fire | bo_fire | flash_fire | wdt_full;
    wire guard_rst = full_rst;
    wire cfg_rst = soft_fire | flash_fire | wdt_full;
    wire [2:0] detect = {~guard_ok, ~cfg_ok, I_WDT_CFG_BAD};
    wire [2:0] next_pend = full_rst ? 3'h0 : (pend | detect);
    wire [3:0] cause_set = {soft_fire & pend[2], bo_fire,
        soft_fire & pend[1], soft_fire & pend[0]};
    wire [3:0] cause_keep = (wr_en & hit_cause) ? wd[3:0] : 4'hF;
    wire [1:0] stat_keep = (wr_en & hit_stat) ? wd[1:0] : 2'h3;
    wire [1:0] irq_clr = (wr_en & hit_irqs) ? wd[1:0] : 2'h0;
    wire [1:0] irq_set = {wdt_warm, full_rst};

    // read mux, upper bits zero
    wire [7:0] rd_mux =
        hit_guard ? reset_guard :
        hit_cause ? {4'h0, reset_cause} :
        hit_bocfg ? brownout_cfg :
        hit_stat ? {6'h00, wdt_stat} :
        hit_irqs ? {6'h00, irq_stat} :
        hit_irqm ? {6'h00, irq_mask} : 8'h00;

    // soft delay state machine
    always_comb
    begin
        next_sd_state = sd_state;
        case (sd_state)
            SD_IDLE: if (next_pend != 3'h0) next_sd_state = SD_WAIT;
            SD_WAIT: if (full_rst) next_sd_state = SD_IDLE;
            default: next_sd_state = SD_IDLE;
        endcase
    end

    // delay and qualify counters
    always_ff @(posedge I_CORE_CLK)
    begin
        if (!I_RST_B)
        begin
            sd_state <= SD_IDLE;
            sd_cnt <= 16'h0000;
            bo_cnt <= 16'h0000;
            pend <= 3'h0;
        end
        else
        begin
            sd_state <= next_sd_state;
            sd_cnt <= (sd_state == SD_WAIT && !full_rst)
                ? sd_cnt + 16'h0001 : 16'h0000;
            bo_cnt <= (!bo_en || !I_LOW_SUPPLY || full_rst) ? 16'h0000
                : (bo_cnt == BO_LAST) ? bo_cnt : bo_cnt + 16'h0001;
            pend <= next_pend;
        end
    end

    // guard and brownout config registers
    always_ff @(posedge I_CORE_CLK)
    begin
        if (!I_RST_B)
        begin
            reset_guard <= `RSC_GUARD_POR;
            brownout_cfg <= `RSC_BO_POR;
        end
        else
        begin
            if (guard_rst)
                reset_guard <= `RSC_GUARD_POR;
            else if (wr_en && hit_guard)
                reset_guard <= wd;
            if (cfg_rst)
                brownout_cfg <= `RSC_BO_POR;
            else if (wr_en && hit_bocfg)
                brownout_cfg <= wd;
        end
    end

    // sticky flags: hardware sets, set wins over clear; irq mask is a plain software-written register
    always_ff @(posedge I_CORE_CLK)
    begin
        if (!I_RST_B)
        begin
            reset_cause <= 4'h0;
            wdt_stat <= 2'h0;
            irq_stat <= 2'h0;
            irq_mask <= 2'h0;
        end
        else
        begin
            reset_cause <= (reset_cause & cause_keep) | cause_set;
            wdt_stat <= (wdt_stat & stat_keep)
                | {wdt_warm, I_WDT_TIMEOUT};
            irq_stat <= (irq_stat & ~irq_clr) | irq_set;
            if (wr_en && hit_irqm)
                irq_mask <= wd[1:0];
        end
    end

    // registered outputs
    always_ff @(posedge I_CORE_CLK)
    begin
        if (!I_RST_B)
        begin
            O_PRDATA <= 32'h0000_0000;
            O_SYS_RST <= 1'b0;
            O_PC_SP_CLR <= 1'b0;
            O_IRQ <= 1'b0;
        end
        else
        begin
            if (rd_setup)
                O_PRDATA <= {24'h00_0000, rd_mux};
            O_SYS_RST <= full_rst;
            O_PC_SP_CLR <= wdt_warm;
            O_IRQ <= |((irq_stat & ~irq_clr | irq_set) & irq_mask);
        end
    end

    // brownout controls toward the analog detector
    assign O_BROWNOUT_EN = bo_en;
    assign O_BROWNOUT_LEVEL = bo_dec[2:0];

    // checks
    default clocking cb @(posedge I_CORE_CLK); endclocking
    default disable iff (!I_RST_B);

    property p_soft_fire;
        (sd_state == SD_WAIT) && (sd_cnt == SOFT_LAST) |=> O_SYS_RST;
    endproperty
    a_soft_fire: assert property (p_soft_fire)
        else $error("soft delay end gave no reset");

    property p_guard_flag;
        soft_fire && pend[2] |=> reset_cause[`RSC_B_GUARD]
            && reset_guard == `RSC_GUARD_POR;
    endproperty
    a_guard_flag: assert property (p_guard_flag)
        else $error("guard reset did not set flag");

    property p_guard_hold;
        reset_cause[`RSC_B_GUARD] && !(wr_en && hit_cause)
            |=> reset_cause[`RSC_B_GUARD];
    endproperty
    a_guard_hold: assert property (p_guard_hold)
        else $error("guard flag cleared by hardware");

    property p_cause_upper;
        rd_setup && hit_cause |=> O_PRDATA[31:4] == 28'h0;
    endproperty
    a_cause_upper: assert property (p_cause_upper)
        else $error("cause upper bits not zero");

    property p_bo_qualify;
        bo_fire |-> $past(I_LOW_SUPPLY) && bo_cnt == BO_LAST;
    endproperty
    a_bo_qualify: assert property (p_bo_qualify)
        else $error("brownout fired unqualified");

    property p_bo_keep;
        bo_fire && !cfg_rst && !(wr_en && hit_bocfg)
            |=> $stable(brownout_cfg) && reset_cause[`RSC_B_BO];
    endproperty
    a_bo_keep: assert property (p_bo_keep)
        else $error("brownout reset changed config");

    property p_save_quiet;
        I_POWER_SAVE |=> bo_cnt == 16'h0000;
    endproperty
    a_save_quiet: assert property (p_save_quiet)
        else $error("brownout active in power save");

    property p_flash_rst;
        wr_en && hit_flash && wd == `RSC_FLASH_KEY |=> O_SYS_RST;
    endproperty
    a_flash_rst: assert property (p_flash_rst)
        else $error("flash key gave no reset");

    property p_warm;
        wdt_warm && !guard_rst && !(wr_en && hit_guard)
            |=> O_PC_SP_CLR && wdt_stat == 2'h3 && $stable(reset_guard);
    endproperty
    a_warm: assert property (p_warm)
        else $error("warm watchdog reset wrong");

    // power-on values of the guard and brownout config
    property p_por_values;
        @(posedge I_CORE_CLK) disable iff (1'h0)
            !I_RST_B |=> reset_guard == `RSC_GUARD_POR
            && brownout_cfg == `RSC_BO_POR;
    endproperty
    a_por_values: assert property (p_por_values)
        else $error("power-on register values wrong");

    // guard corruption starts the soft delay
    property p_guard_detect;
        !guard_ok && sd_state == SD_IDLE && !full_rst
            |=> sd_state == SD_WAIT;
    endproperty
    a_guard_detect: assert property (p_guard_detect)
        else $error("corrupted guard did not start delay");

    property p_sd_count;
        sd_state == SD_WAIT && !full_rst
            |=> sd_cnt == $past(sd_cnt) + 16'h0001;
    endproperty
    a_sd_count: assert property (p_sd_count)
        else $error("soft delay counter did not advance");

    // every full reset restores the guard
    property p_guard_restore;
        full_rst |=> reset_guard == `RSC_GUARD_POR;
    endproperty
    a_guard_restore: assert property (p_guard_restore)
        else $error("full reset left guard unchanged");

    property p_bo_flag;
        bo_fire |=> reset_cause[`RSC_B_BO];
    endproperty
    a_bo_flag: assert property (p_bo_flag)
        else $error("brownout reset did not set flag");

    // decode of the disable and top level codes
    property p_bo_off;
        brownout_cfg == `RSC_BO_OFF |-> !O_BROWNOUT_EN && cfg_ok;
    endproperty
    a_bo_off: assert property (p_bo_off)
        else $error("disable code left detector on");

    property p_bo_top;
        brownout_cfg == `RSC_BO_3V8 |-> O_BROWNOUT_LEVEL == 3'h4 && cfg_ok;
    endproperty
    a_bo_top: assert property (p_bo_top)
        else $error("top level code decoded wrong");

    // bad brownout config: restore and flag
    property p_cfg_restore;
        soft_fire && pend[1] |=> brownout_cfg == `RSC_BO_POR;
    endproperty
    a_cfg_restore: assert property (p_cfg_restore)
        else $error("bad config not restored");

    property p_cfg_flag;
        soft_fire && pend[1] |=> reset_cause[`RSC_B_BOCFG];
    endproperty
    a_cfg_flag: assert property (p_cfg_flag)
        else $error("bad config reset did not set flag");

    property p_cfg_flag_hold;
        reset_cause[`RSC_B_BOCFG] && !(wr_en && hit_cause)
            |=> reset_cause[`RSC_B_BOCFG];
    endproperty
    a_cfg_flag_hold: assert property (p_cfg_flag_hold)
        else $error("config flag cleared by hardware");

    // power save keeps the brownout path quiet
    property p_save_no_rst;
        I_POWER_SAVE |-> !O_BROWNOUT_EN && !bo_fire;
    endproperty
    a_save_no_rst: assert property (p_save_no_rst)
        else $error("brownout enabled in power save");

    // wrong flash value gives no reset
    property p_flash_miss;
        wr_en && hit_flash && wd != `RSC_FLASH_KEY && !soft_fire
            && !bo_fire && !wdt_full |=> !O_SYS_RST;
    endproperty
    a_flash_miss: assert property (p_flash_miss)
        else $error("wrong flash value gave reset");

    // watchdog timeout and watchdog config resets
    property p_wdt_full;
        wdt_full |=> O_SYS_RST && wdt_stat[0];
    endproperty
    a_wdt_full: assert property (p_wdt_full)
        else $error("watchdog timeout gave no full reset");

    property p_wdcfg_flag;
        soft_fire && pend[0] |=> reset_cause[`RSC_B_WDCFG];
    endproperty
    a_wdcfg_flag: assert property (p_wdcfg_flag)
        else $error("watchdog config reset did not set flag");
endmodule : rsc_top

// ==== reset_source_control_tb.sv ====
`timescale 1ns/1ps
`include "rsc_params.svh"
// compare, count and report
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin n_mismatch++; \
$display("Error %0t: got %h exp %h", $time, (a), (e)); end end

module reset_source_control_tb;
localparam int SC = 4;
localparam int BC = 4;
logic clk, rst_b, psel, penable, pwrite, low, psave, wdt_to, wdt_bad;
logic pready, pslverr, sys_rst, pcsp, bo_en, irq, slv;
logic [11:0] paddr;
logic [31:0] pwdata, prdata, r;
logic [2:0] bo_lvl;
logic [7:0] codes [5] = '{8'h66, 8'h55, 8'h33, 8'h99, 8'hAA};
int n_mismatch = 0;
int n_tests = 0;
int n;

rsc_top #(.SOFT_CYC(SC), .BO_CYC(BC)) rsc_top_inst (.I_CORE_CLK(clk),
    .I_RST_B(rst_b), .I_PSEL(psel), .I_PENABLE(penable),
    .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata),
    .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr),
    .I_LOW_SUPPLY(low), .I_POWER_SAVE(psave), .I_WDT_TIMEOUT(wdt_to),
    .I_WDT_CFG_BAD(wdt_bad), .O_SYS_RST(sys_rst), .O_PC_SP_CLR(pcsp),
    .O_BROWNOUT_EN(bo_en), .O_BROWNOUT_LEVEL(bo_lvl), .O_IRQ(irq));

// free running core clock
initial
begin
    clk = 1'b0;
    forever #5 clk = ~clk;
end

// one apb transfer, entered just after a rising edge
task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge clk);
    penable <= 1'b1;
    do
    begin
        @(posedge clk);
    end
    while (pready !== 1'b1);
    r = prdata;
    slv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
endtask : apb

// wait a bounded span for a reset pulse, warm or full
task automatic wait_pulse(input logic warm, input int lim);
    n = 0;
    do
    begin
        @(negedge clk);
        n++;
    end
    while (((warm ? pcsp : sys_rst) !== 1'b1) && n < lim);
endtask : wait_pulse

// strobe one watchdog input for a cycle
task automatic strobe(input logic cfg);
    if (cfg) wdt_bad <= 1'b1;
    else wdt_to <= 1'b1;
    @(posedge clk);
    wdt_bad <= 1'b0;
    wdt_to <= 1'b0;
endtask : strobe

task automatic t_por;
    apb(0, `RSC_OFF_GUARD, 0); `CHK(r[7:0], `RSC_GUARD_POR)
    apb(0, `RSC_OFF_BOCFG, 0); `CHK(r[7:0], `RSC_BO_POR)
    apb(0, `RSC_OFF_CAUSE, 0); `CHK(r, 32'h00000000)
    apb(1, 12'h0FC, 8'h12); `CHK(slv, 1'b1)
    apb(0, 12'h0FC, 0); `CHK(r, 32'h00000000)
endtask : t_por

task automatic t_guard;
    apb(1, `RSC_OFF_GUARD, `RSC_GUARD_ALT); wait_pulse(0, 20);
    `CHK(n, 20)
    @(posedge clk);
    apb(1, `RSC_OFF_GUARD, 8'h00); wait_pulse(0, 40);
    `CHK(n >= SC && n < 40, 1'b1)
    @(posedge clk);
    apb(0, `RSC_OFF_GUARD, 0); `CHK(r[7:0], `RSC_GUARD_POR)
    apb(0, `RSC_OFF_CAUSE, 0); `CHK(r, 32'h00000008)
    apb(1, `RSC_OFF_CAUSE, 8'hF7);
    apb(0, `RSC_OFF_CAUSE, 0); `CHK(r[7:0], 8'h00)
endtask : t_guard

task automatic t_bocfg;
    for (int i = 0; i < 5; i++)
    begin
        apb(1, `RSC_OFF_BOCFG, codes[i]); `CHK(bo_lvl, 3'(i))
        `CHK(bo_en, 1'b1)
    end
    apb(1, `RSC_OFF_BOCFG, `RSC_BO_OFF); `CHK(bo_en, 1'b0)
    apb(1, `RSC_OFF_BOCFG, 8'h12); wait_pulse(0, 40);
    `CHK(n >= SC && n < 40, 1'b1)
    @(posedge clk);
    apb(0, `RSC_OFF_BOCFG, 0); `CHK(r[7:0], `RSC_BO_POR)
    apb(0, `RSC_OFF_CAUSE, 0); `CHK(r[7:0], 8'h02)
    apb(1, `RSC_OFF_CAUSE, 8'h00);
endtask : t_bocfg

task automatic t_brown;
    apb(1, `RSC_OFF_BOCFG, `RSC_BO_3V15);
    low <= 1'b1;
    repeat (BC) @(posedge clk);
    low <= 1'b0;
    wait_pulse(0, 20); `CHK(n, 20)
    @(posedge clk);
    psave <= 1'b1;
    low <= 1'b1;
    wait_pulse(0, 20); `CHK(n, 20)
    `CHK(bo_en, 1'b0)
    @(posedge clk);
    psave <= 1'b0;
    low <= 1'b0;
    @(posedge clk);
    low <= 1'b1;
    wait_pulse(0, 20); `CHK(n >= BC && n < 20, 1'b1)
    @(posedge clk);
    low <= 1'b0;
    @(posedge clk);
    apb(0, `RSC_OFF_BOCFG, 0); `CHK(r[7:0], `RSC_BO_3V15)
    apb(0, `RSC_OFF_CAUSE, 0); `CHK(r[7:0], 8'h04)
    apb(1, `RSC_OFF_CAUSE, 8'h00);
endtask : t_brown

task automatic t_flash;
    fork
        apb(1, `RSC_OFF_FLASH, 8'h54);
        wait_pulse(0, 10);
    join
    `CHK(n, 10)
    @(posedge clk);
    apb(1, `RSC_OFF_IRQM, 8'h01);
    fork
        apb(1, `RSC_OFF_FLASH, `RSC_FLASH_KEY);
        wait_pulse(0, 10);
    join
    `CHK(n, 3)
    repeat (2) @(posedge clk);
    `CHK(irq, 1'b1)
    apb(1, `RSC_OFF_IRQS, 8'h01);
    `CHK(irq, 1'b0)
    apb(1, `RSC_OFF_IRQM, 8'h00);
    apb(1, `RSC_OFF_FLASH, `RSC_FLASH_KEY);
    repeat (2) @(posedge clk);
    `CHK(irq, 1'b0)
    apb(0, `RSC_OFF_IRQS, 0); `CHK(r[0], 1'b1)
    apb(1, `RSC_OFF_IRQS, 8'h03);
endtask : t_flash

task automatic t_wdt;
    apb(1, `RSC_OFF_GUARD, `RSC_GUARD_ALT);
    strobe(0); wait_pulse(0, 10); `CHK(n <= 3, 1'b1)
    @(posedge clk);
    apb(0, `RSC_OFF_STAT, 0); `CHK(r[1:0], 2'b01)
    apb(0, `RSC_OFF_GUARD, 0); `CHK(r[7:0], `RSC_GUARD_POR)
    apb(1, `RSC_OFF_GUARD, `RSC_GUARD_ALT);
    psave <= 1'b1;
    strobe(0); wait_pulse(1, 10); `CHK(n <= 3, 1'b1)
    @(posedge clk);
    psave <= 1'b0;
    apb(0, `RSC_OFF_STAT, 0); `CHK(r[1:0], 2'b11)
    apb(0, `RSC_OFF_GUARD, 0); `CHK(r[7:0], `RSC_GUARD_ALT)
    apb(1, `RSC_OFF_STAT, 8'h00);
    strobe(1); wait_pulse(0, 40); `CHK(n >= SC && n < 40, 1'b1)
    @(posedge clk);
    apb(0, `RSC_OFF_CAUSE, 0); `CHK(r[7:0], 8'h01)
endtask : t_wdt

task automatic tally_and_finish;
    $display("mismatches %0d comparisons %0d", n_mismatch, n_tests);
    if (n_mismatch == 0 && n_tests > 0)
        $display("DONE - PASS");
    else
        $display("DONE - FAIL");
    $finish;
endtask : tally_and_finish

// main sequence
initial
begin
    {rst_b, psel, penable, pwrite, low, psave, wdt_to, wdt_bad} = 8'h00;
    paddr = 12'h000;
    pwdata = 32'h00000000;
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    t_por();
    t_guard();
    t_bocfg();
    t_brown();
    t_flash();
    t_wdt();
    tally_and_finish();
end

// hang guard
initial
begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    tally_and_finish();
end
endmodule : reset_source_control_tb
